// *** hdl/chp_pkg.sv ***
package chp_pkg;
  localparam int CHP_ADDR_W = 12;
  // Direct register offsets from the codec base
  localparam logic [1:0] OFF_INDEX = 2'h0;
  localparam logic [1:0] OFF_DATA = 2'h1;
  localparam logic [1:0] OFF_STATUS = 2'h2;
  localparam logic [1:0] OFF_PIO = 2'h3;
  // Index address fields
  localparam int IA_INIT = 7;
  localparam int IA_MCE = 6;
  localparam int IA_TRD = 5;
  localparam int IA_TOP = 4;
  // Indirect register indices
  localparam logic [4:0] IDX_PFMT = 5'h08;
  localparam logic [4:0] IDX_IFCFG = 5'h09;
  localparam logic [4:0] IDX_MODE = 5'h0c;
  localparam logic [4:0] IDX_EXT = 5'h17;
  localparam logic [4:0] IDX_COMPAT = 5'h19;
  localparam logic [4:0] IDX_CFMT = 5'h1c;
  // Interface configuration bits
  localparam int IF_PEN = 0;
  localparam int IF_CEN = 1;
  localparam int IF_SDC = 2;
  // Mode register fields
  localparam int MODE_FIXED = 7;
  localparam int CMS_LSB = 5;
  localparam logic [1:0] CMS_MODE1 = 2'h0;
  localparam logic [1:0] CMS_MODE2 = 2'h2;
  localparam logic [1:0] CMS_MODE3 = 2'h3;
  // Extended access register fields
  localparam int EXT_XRAE = 3;
  localparam int EXT_XA4 = 2;
  localparam int EXT_XALO = 4;
  // Status bits
  localparam int ST_CAPTURE_READY = 5;
  localparam int ST_SER = 4;
  localparam int ST_PLAYBACK_READY = 1;
  // Format fields
  localparam int FMT_FMT0 = 6;
  localparam int FMT_CL = 5;
  localparam int FMT_SM = 4;
  // Bus strobe timing
  localparam int CLK_NS = 100;
  localparam int STROBE_NS = 300;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYC - 1);
  // Controller registers on AHB
  localparam logic [7:0] H_PIO_CMD = 8'h00;
  localparam logic [7:0] H_PIO_STAT = 8'h04;
  localparam logic [7:0] H_DMA_CTRL = 8'h08;
  localparam logic [7:0] H_DMA_STAT = 8'h0c;
  localparam int HC_WR = 12;
  localparam int HC_OFF = 8;
  localparam int HS_BUSY = 8;
  localparam int HD_EN = 0;
  localparam int HD_CH0_PLAY = 1;
  localparam int HD_BYTE = 8;

  // Index of the last byte of one sample for a given format
  function automatic logic [1:0] chp_last_byte(input logic [7:0] fmt);
    logic wide;
    wide = fmt[FMT_FMT0] & ~fmt[FMT_CL];
    return {wide & fmt[FMT_SM], wide | fmt[FMT_SM]};
  endfunction
endpackage

// *** hdl/chp_isa_if.sv ***
interface chp_isa_if;
  logic [11:0] sa;
  logic aen;
  logic ior_n;
  logic iow_n;
  logic [7:0] h_sd_out;
  logic h_sd_oe;
  logic [7:0] d_sd_out;
  logic d_sd_oe;
  logic [1:0] drq;
  logic [1:0] dack_n;
  logic [7:0] sd;

  // Resolved data bus; undriven lines read as pulled up
  assign sd = d_sd_oe ? d_sd_out : (h_sd_oe ? h_sd_out : 8'hff);

  modport host (
    output sa, aen, ior_n, iow_n, h_sd_out, h_sd_oe, dack_n,
    input drq, sd
  );
  modport codec (
    input sa, aen, ior_n, iow_n, dack_n, sd,
    output d_sd_out, d_sd_oe, drq
  );
endinterface

// *** hdl/chp_host_end.sv ***
module chp_host_end #(
  parameter logic [11:0] IO_BASE = 12'h100
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Codec bus
  chp_isa_if.host isa
);
  import chp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_ADDR, H_STRB, H_HOLD} chp_hfsm_e;
  typedef struct packed {
    chp_hfsm_e fsm;
    logic [1:0] cnt;
    logic [11:0] sa;
    logic aen;
    logic ior_n;
    logic iow_n;
    logic [7:0] sd_out;
    logic sd_oe;
    logic [1:0] dack_n;
    logic is_dma;
    logic wr;
    logic pend;
    logic [1:0] cmd_off;
    logic cmd_wr;
    logic [7:0] cmd_data;
    logic [7:0] rd_data;
    logic dma_en;
    logic ch0_play;
    logic [7:0] dma_byte;
    logic [7:0] cap_byte;
    logic [15:0] dma_count;
    logic a_wr;
    logic [7:0] a_off;
    logic [31:0] hrdata;
    logic hreadyout;
  } chp_host_s;

  chp_host_s st_ff;
  chp_host_s nxt_st;
  logic a_valid;
  logic busy;

  always_comb begin
    nxt_st = st_ff;
    a_valid = hsel & htrans[1] & hready;
    busy = st_ff.pend | (st_ff.fsm != H_IDLE);
    nxt_st.hreadyout = 1'b1;
    // Zero-wait slave: read data is fetched during the address phase
    if (a_valid) begin
      nxt_st.a_wr = hwrite;
      nxt_st.a_off = haddr[7:0];
      case (haddr[7:0])
        H_PIO_STAT: nxt_st.hrdata = {23'h0, busy, st_ff.rd_data};
        H_DMA_CTRL: nxt_st.hrdata = {16'h0, st_ff.dma_byte, 6'h0, st_ff.ch0_play, st_ff.dma_en};
        H_DMA_STAT: nxt_st.hrdata = {8'h0, st_ff.dma_count, st_ff.cap_byte};
        default: nxt_st.hrdata = 32'h0;
      endcase
    end else begin
      nxt_st.a_wr = 1'b0;
    end
    if (st_ff.a_wr) begin
      case (st_ff.a_off)
        H_PIO_CMD: begin
          // A command while busy is dropped; software polls the busy flag
          if (!busy) begin
            nxt_st.pend = 1'b1;
            nxt_st.cmd_data = hwdata[7:0];
            nxt_st.cmd_off = hwdata[HC_OFF+:2];
            nxt_st.cmd_wr = hwdata[HC_WR];
          end
        end
        H_DMA_CTRL: begin
          nxt_st.dma_en = hwdata[HD_EN];
          nxt_st.ch0_play = hwdata[HD_CH0_PLAY];
          nxt_st.dma_byte = hwdata[HD_BYTE+:8];
        end
        default: begin
        end
      endcase
    end
    case (st_ff.fsm)
      H_IDLE: begin
        if (st_ff.pend) begin
          nxt_st.sa = IO_BASE + {10'h0, st_ff.cmd_off};
          nxt_st.aen = 1'b0;
          nxt_st.is_dma = 1'b0;
          nxt_st.wr = st_ff.cmd_wr;
          nxt_st.sd_out = st_ff.cmd_data;
          nxt_st.sd_oe = st_ff.cmd_wr;
          nxt_st.fsm = H_ADDR;
        end else if (st_ff.dma_en && isa.drq != 2'b00) begin
          // While dma_en is set any raised request is answered, even while the codec enables are being cleared
          nxt_st.aen = 1'b1;
          nxt_st.is_dma = 1'b1;
          nxt_st.dack_n = isa.drq[0] ? 2'b10 : 2'b01;
          nxt_st.wr = isa.drq[0] & st_ff.ch0_play;
          nxt_st.sd_out = st_ff.dma_byte;
          nxt_st.sd_oe = isa.drq[0] & st_ff.ch0_play;
          nxt_st.fsm = H_ADDR;
        end
      end
      H_ADDR: begin
        nxt_st.ior_n = st_ff.wr;
        nxt_st.iow_n = ~st_ff.wr;
        nxt_st.cnt = 2'h0;
        nxt_st.fsm = H_STRB;
      end
      H_STRB: begin
        nxt_st.cnt = st_ff.cnt + 2'h1;
        if (st_ff.cnt == STROBE_LAST) begin
          if (!st_ff.wr && st_ff.is_dma) begin
            nxt_st.cap_byte = isa.sd;
          end else if (!st_ff.wr) begin
            nxt_st.rd_data = isa.sd;
          end
          nxt_st.ior_n = 1'b1;
          nxt_st.iow_n = 1'b1;
          nxt_st.fsm = H_HOLD;
        end
      end
      H_HOLD: begin
        // Address, acknowledge and data stay one cycle past the strobe
        nxt_st.sd_oe = 1'b0;
        nxt_st.aen = 1'b1;
        nxt_st.dack_n = 2'b11;
        if (st_ff.is_dma) begin
          nxt_st.dma_count = st_ff.dma_count + 16'h1;
        end else begin
          nxt_st.pend = 1'b0;
        end
        nxt_st.fsm = H_IDLE;
      end
      default: nxt_st.fsm = H_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{fsm: H_IDLE, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1, dack_n: 2'b11,
                 hreadyout: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout = st_ff.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = st_ff.hrdata;
  assign isa.sa = st_ff.sa;
  assign isa.aen = st_ff.aen;
  assign isa.ior_n = st_ff.ior_n;
  assign isa.iow_n = st_ff.iow_n;
  assign isa.h_sd_out = st_ff.sd_out;
  assign isa.h_sd_oe = st_ff.sd_oe;
  assign isa.dack_n = st_ff.dack_n;
endmodule

// *** hdl/chp_codec_end.sv ***
// Notes on behaviour
// - Four byte locations: index, data, status, PIO
// - PIO cycle needs base match, AEN low
// - Drive read data while IOR held
// - Writes latch on IOW rising edge
// - Request when buffers need service; host acknowledges
// - Request held until whole sample moved
// - DACK with AEN high ignores address
// - Raised request stays until sample complete
// - Enable clear stops only at sample boundary
// - Host finishes sample for late request
// - Channel select routing by channel count
// - Dual mode: enables change without mode-change flag
// - Software clears single-channel bit for dual
// - Single channel: capture on playback channel, exclusive
// - Single channel prefers playback; PIO unaffected
// - Modes two, three: capture format from 28
// - Thirty-two indirect registers selected by index
// - Mode one reaches only registers 0-15
// - Software writes reserved bits zero, masks reads
// - Select 10 enters mode two, 00 returns
// - Select 11 enters mode three, extended registers
// - Top index bit decoded only mode two up
module chp_codec_end #(
  parameter logic [3:0] CHIP_ID = 4'h5,
  parameter logic [7:0] COMPAT_ID = 8'h00
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Host bus
  chp_isa_if.codec isa,
  // Configuration
  input wire logic [chp_pkg::CHP_ADDR_W-1:0] codec_io_base,
  input wire logic two_dma_channels,
  // Playback stream
  input wire logic play_need,
  output logic [7:0] play_byte,
  output logic play_stb,
  // Capture stream
  input wire logic cap_valid,
  input wire logic [31:0] cap_sample,
  output logic cap_done
);
  import chp_pkg::*;

  typedef struct packed {
    logic ior_d;
    logic iow_d;
    logic [7:0] index;
    logic [31:0][7:0] ireg;
    logic [31:0][7:0] xreg;
    logic sample_error;
    logic [1:0] play_cnt;
    logic [1:0] cap_cnt;
    logic play_req;
    logic cap_req;
    logic [7:0] sd_out;
    logic sd_oe;
    logic [1:0] drq;
    logic [7:0] play_byte;
    logic play_stb;
    logic cap_done;
  } chp_codec_s;

  chp_codec_s st_ff;
  chp_codec_s nxt_st;
  logic [1:0] mode;
  logic hi_mode;
  logic [4:0] eff_idx;
  logic ext_sel;
  logic [4:0] xa;
  logic single;
  logic play_enable;
  logic capture_enable;
  logic [1:0] play_last;
  logic [1:0] cap_last;
  logic pio_sel;
  logic dma_play;
  logic dma_cap;
  logic ior_rise;
  logic iow_rise;
  logic [7:0] cap_byte;
  logic [7:0] ind_val;
  logic [7:0] rd_val;
  logic [7:0] wd;

  always_comb begin
    nxt_st = st_ff;
    mode = st_ff.ireg[IDX_MODE][CMS_LSB+:2];
    hi_mode = mode[1];
    eff_idx = {st_ff.index[IA_TOP] & hi_mode, st_ff.index[3:0]};
    xa = {st_ff.ireg[IDX_EXT][EXT_XA4], st_ff.ireg[IDX_EXT][EXT_XALO+:4]};
    ext_sel = (mode == CMS_MODE3) && (eff_idx == IDX_EXT)
              && st_ff.ireg[IDX_EXT][EXT_XRAE];
    play_enable = st_ff.ireg[IDX_IFCFG][IF_PEN];
    capture_enable = st_ff.ireg[IDX_IFCFG][IF_CEN];
    single = st_ff.ireg[IDX_IFCFG][IF_SDC] | ~two_dma_channels;
    play_last = chp_last_byte(st_ff.ireg[IDX_PFMT]);
    cap_last = chp_last_byte(hi_mode ? st_ff.ireg[IDX_CFMT] : st_ff.ireg[IDX_PFMT]);
    // Acknowledged cycles never look at the address lines
    dma_play = ~isa.dack_n[0] & isa.aen & st_ff.play_req;
    dma_cap = isa.aen & st_ff.cap_req & (single ? ~isa.dack_n[0] & ~st_ff.play_req
                                                : ~isa.dack_n[1]);
    pio_sel = ~isa.aen && isa.sa[11:2] == codec_io_base[11:2];
    ior_rise = isa.ior_n & ~st_ff.ior_d;
    iow_rise = isa.iow_n & ~st_ff.iow_d;
    nxt_st.ior_d = isa.ior_n;
    nxt_st.iow_d = isa.iow_n;
    cap_byte = cap_sample[{st_ff.cap_cnt, 3'h0}+:8];
    wd = isa.sd;
    case (eff_idx)
      IDX_MODE: ind_val = {1'b1, mode, 1'b0, CHIP_ID};
      IDX_COMPAT: ind_val = COMPAT_ID;
      default: ind_val = st_ff.ireg[eff_idx];
    endcase
    case (isa.sa[1:0])
      OFF_INDEX: rd_val = {1'b0, st_ff.index[6:0]};
      OFF_DATA: rd_val = ext_sel ? st_ff.xreg[xa] : ind_val;
      OFF_STATUS: begin
        rd_val = 8'h00;
        rd_val[ST_CAPTURE_READY] = cap_valid;
        rd_val[ST_SER] = st_ff.sample_error;
        rd_val[ST_PLAYBACK_READY] = play_need;
      end
      default: rd_val = cap_byte;
    endcase
    // Data drives from the cycle after the strobe is seen low
    nxt_st.sd_oe = ~isa.ior_n & (pio_sel | dma_cap);
    nxt_st.sd_out = dma_cap ? cap_byte : rd_val;
    nxt_st.play_stb = 1'b0;
    nxt_st.cap_done = 1'b0;
    // New samples start only on a boundary, so clearing an enable never splits one
    if (play_enable && play_need && !st_ff.play_req && !st_ff.play_stb && st_ff.play_cnt == 2'h0
        && !(single && st_ff.cap_req)) begin
      nxt_st.play_req = 1'b1;
    end
    if (capture_enable && cap_valid && !st_ff.cap_req && !st_ff.cap_done && st_ff.cap_cnt == 2'h0
        && !(single && (st_ff.play_req || (play_enable && play_need)))) begin
      nxt_st.cap_req = 1'b1;
    end
    if (iow_rise && (dma_play || (pio_sel && isa.sa[1:0] == OFF_PIO))) begin
      nxt_st.play_byte = wd;
      nxt_st.play_stb = 1'b1;
      if (!play_need && !dma_play) begin
        nxt_st.sample_error = 1'b1;
      end
      nxt_st.play_cnt = st_ff.play_cnt + 2'h1;
      if (st_ff.play_cnt == play_last) begin
        nxt_st.play_cnt = 2'h0;
        nxt_st.play_req = 1'b0;
      end
    end else if (iow_rise && pio_sel) begin
      case (isa.sa[1:0])
        OFF_INDEX: nxt_st.index = {1'b0, wd[IA_MCE:0]};
        OFF_DATA: begin
          if (ext_sel) begin
            nxt_st.xreg[xa] = wd;
          end else if (eff_idx == IDX_MODE) begin
            nxt_st.ireg[IDX_MODE] = {1'b0, wd[CMS_LSB+:2], 5'h00};
          end else if (eff_idx == IDX_IFCFG && !st_ff.index[IA_MCE]) begin
            // Without the mode-change flag only dual mode may flip the enables
            if (!single) begin
              nxt_st.ireg[IDX_IFCFG] = {st_ff.ireg[IDX_IFCFG][7:2], wd[1:0]};
            end
          end else if (eff_idx != IDX_COMPAT) begin
            nxt_st.ireg[eff_idx] = wd;
          end
        end
        OFF_STATUS: nxt_st.sample_error = 1'b0;
        default: begin
        end
      endcase
    end
    if (ior_rise && (dma_cap || (pio_sel && isa.sa[1:0] == OFF_PIO))) begin
      if (!cap_valid) begin
        nxt_st.sample_error = 1'b1;
      end
      nxt_st.cap_cnt = st_ff.cap_cnt + 2'h1;
      if (st_ff.cap_cnt == cap_last) begin
        nxt_st.cap_cnt = 2'h0;
        nxt_st.cap_done = 1'b1;
        nxt_st.cap_req = 1'b0;
      end
    end
    nxt_st.drq[0] = nxt_st.play_req | (single & nxt_st.cap_req);
    nxt_st.drq[1] = ~single & nxt_st.cap_req;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{ior_d: 1'b1, iow_d: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign isa.d_sd_out = st_ff.sd_out;
  assign isa.d_sd_oe = st_ff.sd_oe;
  assign isa.drq = st_ff.drq;
  assign play_byte = st_ff.play_byte;
  assign play_stb = st_ff.play_stb;
  assign cap_done = st_ff.cap_done;
endmodule

// *** verification/chp_isa_assertions.sv ***
module chp_isa_assertions (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Codec bus
  input wire logic [11:0] sa,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic h_sd_oe,
  input wire logic d_sd_oe,
  input wire logic [1:0] drq,
  input wire logic [1:0] dack_n,
  // Configuration
  input wire logic two_dma_channels,
  input wire logic [11:0] codec_io_base
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic pio_hit;
  // Follows the live base so a moved codec is not expected to answer
  assign pio_hit = !aen && sa[11:2] == codec_io_base[11:2];
  sequence s_pio_rd;
    !ior_n && pio_hit;
  endsequence
  sequence s_strobe_w;
    !iow_n [*3] ##1 iow_n;
  endsequence
  sequence s_strobe_r;
    !ior_n [*3] ##1 ior_n;
  endsequence
  // The last byte's strobe ends while still acknowledged, so an idle request must stay
  sequence s_unacked;
    drq[0] && dack_n[0];
  endsequence
  property p_rd_drive;
    s_pio_rd [*3] |-> d_sd_oe;
  endproperty
  property p_drive_cause;
    $rose(d_sd_oe) |-> $past(!ior_n) && $past(pio_hit || aen && dack_n != 2'h3);
  endproperty
  property p_rd_release;
    ior_n [*3] |-> !d_sd_oe;
  endproperty
  property p_bus_excl;
    !(d_sd_oe && h_sd_oe);
  endproperty
  property p_wr_strobe;
    $fell(iow_n) |-> s_strobe_w;
  endproperty
  property p_rd_strobe;
    $fell(ior_n) |-> s_strobe_r;
  endproperty
  property p_wr_hold;
    !iow_n && $past(!iow_n) |-> $stable(sa) && $stable(aen) && $stable(dack_n);
  endproperty
  property p_req_hold;
    s_unacked |=> drq[0];
  endproperty
  property p_chan_single;
    !two_dma_channels |-> drq[1] == 1'b0;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read data not driven");
  a_drive_cause: assert property (p_drive_cause) else $error("drive without cycle");
  a_rd_release: assert property (p_rd_release) else $error("data bus not released");
  a_bus_excl: assert property (p_bus_excl) else $error("both ends drive data");
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe length");
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe length");
  a_wr_hold: assert property (p_wr_hold) else $error("address moved in strobe");
  a_req_hold: assert property (p_req_hold) else $error("request dropped unserved");
  a_chan_single: assert property (p_chan_single) else $error("request on channel 1");
endmodule

// *** verification/codec_host_pio_dma_port_test.sv ***
module codec_host_pio_dma_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  import chp_pkg::*;
  localparam logic [11:0] IO_BASE = 12'h100;
  localparam logic [7:0] FM[4] = '{8'h00, 8'h10, 8'h40, 8'h50};
  localparam int NB[4] = '{1, 2, 2, 4};
  logic hclk = 0, hresetn = 0, hwrite = 0, hreadyout, play_need = 0, play_stb;
  logic two_dma_channels = 1, cap_valid = 0, cap_done;
  int rd_sent = 0, rd_seen = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, cap_sample = 0, rd_val;
  logic [11:0] codec_io_base = IO_BASE;
  logic [7:0] play_byte;
  logic [63:0] rq[$];
  logic [7:0] pq[$];
  int miscompares = 0, num_checks = 0, prem = 0, ncap = 0, exp_cnt = 0;
  always #50 hclk = ~hclk;
  chp_isa_if bus ();
  chp_host_end #(.IO_BASE(IO_BASE)) chp_host_end_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .isa(bus));
  // Identity values are arbitrary
  chp_codec_end #(.CHIP_ID(4'h9), .COMPAT_ID(8'h3c)) chp_codec_end_i (.hclk(hclk),
    .hresetn(hresetn), .isa(bus), .codec_io_base(codec_io_base),
    .two_dma_channels(two_dma_channels), .play_need(play_need), .play_byte(play_byte),
    .play_stb(play_stb), .cap_valid(cap_valid), .cap_sample(cap_sample), .cap_done(cap_done));
  chp_isa_assertions chp_isa_assertions_i (.hclk(hclk), .hresetn(hresetn),
    .sa(bus.sa), .aen(bus.aen), .ior_n(bus.ior_n), .iow_n(bus.iow_n), .h_sd_oe(bus.h_sd_oe),
    .d_sd_oe(bus.d_sd_oe), .drq(bus.drq), .dack_n(bus.dack_n),
    .two_dma_channels(two_dma_channels), .codec_io_base(codec_io_base));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tmo(input logic bad);
    if (bad) begin
      miscompares++;
      $display("CHECK FAILED %0t wait expired", $time);
      report_and_stop();
    end
  endtask
  task automatic cmp_rd(input logic [31:0] g, e, m);
    num_checks++;
    if (((g ^ e) & m) !== 32'h0) begin
      miscompares++;
      $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     input logic c, output logic [31:0] rd);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 80);
    rd = hrdata;
    rd_val <= hrdata;
    rd_sent <= rd_sent + int'(c);
    tmo(n >= 80);
  endtask
  task automatic ahb_chk(input logic [7:0] a, input logic [31:0] e, m);
    logic [31:0] r;
    rq.push_back({m, e});
    ahb(a, 1'b0, 32'h0, 1'b1, r);
  endtask
  task automatic cyc(input logic w, input logic [1:0] off, input logic [7:0] d);
    logic [31:0] r;
    int n;
    ahb(H_PIO_CMD, 1'b1, {19'h0, w, 2'h0, off, d}, 1'b0, r);
    n = 0;
    do begin
      ahb(H_PIO_STAT, 1'b0, 32'h0, 1'b0, r);
      n++;
    end while (r[HS_BUSY] !== 1'b0 && n < 30);
    tmo(n >= 30);
  endtask
  task automatic cr(input logic [1:0] off, input logic [7:0] e, m);
    cyc(1'b0, off, 8'h0);
    ahb_chk(H_PIO_STAT, {24'h0, e}, {23'h0, 1'b1, m});
  endtask
  task automatic iw(input logic [4:0] idx, input logic [7:0] d);
    cyc(1'b1, OFF_INDEX, {3'h0, idx});
    cyc(1'b1, OFF_DATA, d);
  endtask
  task automatic ir(input logic [4:0] idx, input logic [7:0] e, m);
    cyc(1'b1, OFF_INDEX, {3'h0, idx});
    cr(OFF_DATA, e, m);
  endtask
  // Expected notes are taken off in arrival order
  always @(posedge hclk) begin
    if (rd_seen != rd_sent) begin
      rd_seen <= rd_seen + 1;
      cmp_rd(rd_val, rq[0][31:0], rq[0][63:32]);
      void'(rq.pop_front());
    end
    if (play_stb) begin
      cmp_byte(play_byte, pq.pop_front());
      prem--;
      if (prem == 0) play_need <= 1'b0;
    end
    if (cap_done) begin
      ncap++;
      cap_valid <= 1'b0;
    end
  end
  initial begin
    logic [31:0] v;
    logic [7:0] b;
    int n;
    v = $urandom(89723);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    v = $urandom;
    iw(IDX_PFMT, v[7:0]);
    ir(IDX_PFMT, v[7:0], 8'hff);
    cyc(1'b1, OFF_INDEX, 8'he8);
    cr(OFF_INDEX, 8'h68, 8'hff);
    ir(IDX_CFMT, 8'h89, 8'hef);
    iw(IDX_MODE, 8'h40);
    ir(IDX_MODE, 8'hc9, 8'hef);
    iw(IDX_CFMT, 8'ha0);
    ir(IDX_CFMT, 8'ha0, 8'hf0);
    ir(IDX_COMPAT, 8'h3c, 8'hff);
    iw(IDX_MODE, 8'h60);
    ir(IDX_MODE, 8'he9, 8'hef);
    iw(IDX_MODE, 8'h00);
    ir(IDX_CFMT, 8'h89, 8'hef);
    codec_io_base <= IO_BASE + 12'h10;
    cyc(1'b1, OFF_INDEX, 8'h0c);
    cr(OFF_INDEX, 8'hff, 8'hff);
    codec_io_base <= IO_BASE;
    cr(OFF_INDEX, 8'h1c, 8'hff);
    // Single-channel and reserved bits kept clear while two channels exist
    iw(IDX_IFCFG, 8'h01);
    for (int i = 0; i < 4; i++) begin
      iw(IDX_PFMT, FM[i]);
      b = 8'($urandom);
      ahb(H_DMA_CTRL, 1'b1, {16'h0, b, 8'h03}, 1'b0, v);
      prem = NB[i];
      repeat (NB[i]) pq.push_back(b);
      exp_cnt += NB[i];
      play_need <= 1'b1;
      for (n = 0; n < 400 && prem != 0; n++) @(posedge hclk);
      tmo(prem != 0);
      repeat (10) @(posedge hclk);
      ahb_chk(H_DMA_STAT, {8'h0, 16'(exp_cnt), 8'h0}, 32'h00ffff00);
    end
    iw(IDX_IFCFG, 8'h00);
    play_need <= 1'b1;
    repeat (30) @(posedge hclk);
    play_need <= 1'b0;
    ahb_chk(H_DMA_STAT, {8'h0, 16'(exp_cnt), 8'h0}, 32'h00ffff00);
    two_dma_channels <= 1'b0;
    cyc(1'b1, OFF_INDEX, {3'h2, IDX_IFCFG});
    cyc(1'b1, OFF_DATA, 8'h02);
    ahb(H_DMA_CTRL, 1'b1, 32'h1, 1'b0, v);
    v = $urandom;
    cap_sample <= v;
    cap_valid <= 1'b1;
    for (n = 0; n < 400 && ncap == 0; n++) @(posedge hclk);
    tmo(ncap == 0);
    exp_cnt += 4;
    ahb_chk(H_DMA_STAT, {8'h0, 16'(exp_cnt), v[31:24]}, 32'h00ffffff);
    cyc(1'b1, OFF_DATA, 8'h00);
    v = $urandom;
    cap_sample <= v;
    cap_valid <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      cr(OFF_PIO, v[8*i+:8], 8'hff);
    end
    ahb_chk(H_DMA_STAT, {8'h0, 16'(exp_cnt), 8'h0}, 32'h00ffff00);
    tmo(ncap != 2);
    // Mode two takes the one-byte capture format, not the four-byte playback one
    iw(IDX_MODE, 8'h40);
    v = $urandom;
    cap_sample <= v;
    cap_valid <= 1'b1;
    cr(OFF_PIO, v[7:0], 8'hff);
    tmo(ncap != 3);
    // Playback byte without a pending sample flags a sample error
    b = 8'($urandom);
    pq.push_back(b);
    prem = 1;
    cyc(1'b1, OFF_PIO, b);
    cr(OFF_STATUS, 8'h10, 8'h32);
    cyc(1'b1, OFF_STATUS, 8'h00);
    cr(OFF_STATUS, 8'h00, 8'h32);
    // Let the last notes be compared before the verdict
    repeat (2) @(posedge hclk);
    tmo(rq.size() != 0 || pq.size() != 0);
    report_and_stop();
  end
endmodule
